/* File: verilog/iopb_top.sv */
// I/O pin, K port, digit, segment and RAM bank instruction execution with Wishbone access
// Summary of operation
// - Pin low: data zero, direction output
// - Pin high: data one, direction output
// - Pin to input, data latch kept
// - Status into pin data, direction output
// - Previous pin sample written to bit B
// - Pin-to-memory keeps pin direction unchanged
// - Accumulator to port latch, driven if DL8
// - Port lines stored into addressed nibble
// - DL8 set: port reads see latch
// - Port lines loaded into accumulator
// - Status set when any port line high
// - Segment term from SEGMENT_SELECT_DIGIT_LATCH, status, accumulator
// - Point latch supplies segment H later
// - Y selects digit latch to set/clear
// - Invert X bit three only
// - Toggle direct select; chooses RAM bank
//
// The register offsets and register access over Wishbone were chosen for this implementation.
`default_nettype none
module iopb_top
  import iopb_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Single I/O pin
  input wire logic io_pin_i,
  output logic io_pin_o,
  output logic io_pin_oe_n_o,
  // K port
  input wire logic [3:0] kport_i,
  output logic [3:0] kport_o,
  output logic kport_oe_n_o,
  // R outputs and segments
  output logic [7:0] r_o,
  output logic [7:0] seg_o,
  output logic [3:0] seg_digit_o,
  output logic seg_wr_o
);
  // Full state of the block
  typedef struct packed {
    logic ack; // Bus acknowledge
    logic [31:0] rdat; // Bus read data
    logic [3:0] acc; // Accumulator
    logic status; // Status bit
    logic [3:0] y; // Y register
    logic [3:0] x; // X register
    logic direct_access_bank; // Direct-access bank select
    logic [15:0] dl; // Digit latches
    logic [3:0] klat; // Port latch
    logic io_dat; // Pin data latch
    logic io_out; // Pin direction, one is output
    logic io_smp; // Pin level sampled each instruction
    logic dp; // Decimal-point latch
    logic [7:0] seg; // Last segment word
    logic [3:0] seg_dig; // Digit of last segment word
    logic seg_wr; // Segment write pulse
    logic mem_wr; // Memory write pulse
    logic [3:0] mem_bank; // Bank of memory write
    logic [3:0] mem_wy; // Word of memory write
    logic [3:0] mem_data; // Data of memory write
    logic [3:0] mem_mask; // Bit mask of memory write
    logic [3:0] mem_nib; // Current addressed RAM nibble, loaded by software
  } iopb_state_t;

  iopb_state_t s_q, s_d;
  logic [8:0] instr; // Instruction word under execution
  logic exec; // One-cycle instruction strobe
  logic [5:0] term; // Segment decode address
  logic [6:0] seg_ag; // Segment decode result
  logic [3:0] kline; // Level seen on port lines
  logic wr_take; // Write request taken this cycle

  // One-hot mask for the bit number of a bit instruction
  function automatic logic [3:0] iopb_bit_mask(input logic [1:0] b);
    return 4'h1 << b;
  endfunction : iopb_bit_mask

  // Decoded instruction carrier
  iopb_exec_if dbus ();

  // Instruction decoder
  iopb_decode u_dec (
    .instr_i(instr),
    .dec(dbus.dec)
  );

  // Segment decode array
  iopb_segrom u_seg (
    .term_i(term),
    .seg_o(seg_ag)
  );

  // Strobe: a write to the instruction register executes it
  // Write taken once per bus cycle; the pending ack blocks a repeat
  assign wr_take = wb_cyc_i && wb_stb_i && wb_we_i && !s_q.ack;
  assign exec = wr_take && (wb_adr_i == ADR_INSTR) && wb_sel_i[0];
  assign instr = {wb_dat_i[8], wb_dat_i[7:0]};
  assign term = {s_q.dl[SEG_SEL_DL], s_q.status, s_q.acc};
  // Port lines show the latch while driven
  assign kline = s_q.dl[PORT_DIR_DL] ? s_q.klat : kport_i;

  // Next-state logic
  always_comb begin
    s_d = s_q;
    s_d.ack = wb_cyc_i && wb_stb_i && !s_q.ack;
    s_d.seg_wr = 1'b0;
    s_d.mem_wr = 1'b0;
    // Read mux
    unique case (wb_adr_i)
      ADR_INSTR: s_d.rdat = {27'h0, s_q.status, s_q.acc};
      ADR_REGS: s_d.rdat = {19'h0, s_q.direct_access_bank, s_q.x, s_q.y, 4'h0} | {28'h0, s_q.mem_nib};
      ADR_LATCH: s_d.rdat = {s_q.dl, 8'h0, s_q.dp, s_q.io_smp, s_q.io_out, s_q.io_dat, s_q.klat};
      ADR_MEMWR: s_d.rdat = {16'h0, s_q.mem_bank, s_q.mem_wy, s_q.mem_data, s_q.mem_mask};
      ADR_SEG: s_d.rdat = {20'h0, s_q.seg_dig, s_q.seg};
      default: s_d.rdat = 32'h0;
    endcase
    // Software loads accumulator, status, Y and RAM nibble
    if (wr_take && wb_adr_i == ADR_REGS) begin
      if (wb_sel_i[0]) begin
        s_d.mem_nib = wb_dat_i[3:0];
        s_d.y = wb_dat_i[7:4];
      end
      if (wb_sel_i[1]) begin
        s_d.acc = wb_dat_i[11:8];
        s_d.status = wb_dat_i[12];
      end
    end
    if (exec) begin
      // Pin level seen during this instruction, used by the next one
      s_d.io_smp = s_q.io_out ? s_q.io_dat : io_pin_i;
      s_d.status = 1'b1;
      unique case (dbus.op)
        // Single pin commands
        IOPB_PIN_LOW: begin
          s_d.io_dat = 1'b0;
          s_d.io_out = 1'b1;
        end
        IOPB_PIN_HIGH: begin
          s_d.io_dat = 1'b1;
          s_d.io_out = 1'b1;
        end
        IOPB_PIN_IN: begin
          s_d.io_out = 1'b0;
        end
        IOPB_STAT_PIN: begin
          s_d.io_dat = s_q.status;
          s_d.io_out = 1'b1;
        end
        IOPB_PIN_MEM: begin
          // Direction untouched; reads the driven value when output
          s_d.mem_wr = 1'b1;
          s_d.mem_mask = iopb_bit_mask(dbus.field[1:0]);
          s_d.mem_data = {4{s_q.io_smp}} & iopb_bit_mask(dbus.field[1:0]);
          s_d.mem_nib = (s_q.mem_nib & ~iopb_bit_mask(dbus.field[1:0])) | s_d.mem_data;
        end
        // Port commands
        IOPB_ACC_PORT: s_d.klat = s_q.acc;
        IOPB_PORT_MEM: begin
          s_d.mem_wr = 1'b1;
          s_d.mem_mask = 4'hF;
          s_d.mem_data = kline;
          s_d.mem_nib = kline;
        end
        IOPB_PORT_ACC: s_d.acc = kline;
        IOPB_PORT_NZ: s_d.status = |kline;
        // Display commands
        IOPB_SEG_OUT: begin
          s_d.seg = {s_q.dp, seg_ag};
          s_d.seg_dig = s_q.y;
          s_d.seg_wr = 1'b1;
        end
        IOPB_DP_SET: s_d.dp = 1'b1;
        IOPB_DP_CLR: s_d.dp = 1'b0;
        // Digit latch and bank commands
        IOPB_DL_SET: s_d.dl[s_q.y] = 1'b1;
        IOPB_DL_CLR: s_d.dl[s_q.y] = 1'b0;
        IOPB_X_LOAD: begin
          // Only constants of existing banks are expected
          s_d.x = dbus.field;
          s_d.direct_access_bank = 1'b0;
        end
        IOPB_X_MSB: s_d.x = {~s_q.x[3], s_q.x[2:0]};
        IOPB_DAM_TGL: s_d.direct_access_bank = ~s_q.direct_access_bank;
        IOPB_NONE: ;
      endcase
      // Bank of any memory write follows the direct select
      s_d.mem_bank = s_q.direct_access_bank ? DIRECT_BANK_CODE : s_q.x;
      s_d.mem_wy = s_q.y;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.x <= X_RESET;
      s_q.dl <= DL_RESET;
      s_q.klat <= PORT_LATCH_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdat;
  assign io_pin_o = s_q.io_dat;
  assign io_pin_oe_n_o = ~s_q.io_out;
  assign kport_o = s_q.klat;
  assign kport_oe_n_o = ~s_q.dl[PORT_DIR_DL];
  assign r_o = s_q.dl[7:0];
  assign seg_o = s_q.seg;
  assign seg_digit_o = s_q.seg_dig;
  assign seg_wr_o = s_q.seg_wr;

  // Assertions
  sequence low_cmd_s;
    exec && dbus.op == IOPB_PIN_LOW;
  endsequence
  sequence high_cmd_s;
    exec && dbus.op == IOPB_PIN_HIGH;
  endsequence
  pin_low_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    low_cmd_s |=> !io_pin_o && !io_pin_oe_n_o) else $error("pin low not driven");
  pin_high_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    high_cmd_s |=> io_pin_o && !io_pin_oe_n_o) else $error("pin high not driven");
  pin_input_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dbus.op == IOPB_PIN_IN |=> io_pin_oe_n_o && $stable(io_pin_o)) else $error("pin input wrong");
  stat_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dbus.op == IOPB_STAT_PIN |=> io_pin_o == $past(s_q.status)) else $error("status to pin wrong");
  pin_mem_dir_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dbus.op == IOPB_PIN_MEM |=> $stable(io_pin_oe_n_o) && s_q.mem_wr) else $error("pin to mem wrong");
  port_oe_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dbus.op == IOPB_ACC_PORT |=> kport_o == $past(s_q.acc) && $stable(kport_oe_n_o))
    else $error("port latch wrong");
  port_nz_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dbus.op == IOPB_PORT_NZ |=> s_q.status == |$past(kline)) else $error("nonzero test wrong");
  status_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dbus.op != IOPB_PORT_NZ |=> s_q.status) else $error("status not set");
  xmsb_flip_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dbus.op == IOPB_X_MSB |=> s_q.x == ($past(s_q.x) ^ 4'h8)) else $error("x msb wrong");
  bank_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dbus.op == IOPB_X_LOAD |=> !s_q.direct_access_bank && s_q.x == $past(dbus.field)) else $error("bank load wrong");
  seg_point_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dbus.op == IOPB_SEG_OUT |=> seg_wr_o && seg_o[7] == $past(s_q.dp)) else $error("segment H wrong");

  // Pin to memory in two steps: the command, then the reported write
  sequence pin_mem_cmd_s;
    exec && dbus.op == IOPB_PIN_MEM;
  endsequence

  // Write report carries the mask of the commanded bit
  sequence mem_report_s;
    s_q.mem_wr && s_q.mem_mask == iopb_bit_mask($past(dbus.field[1:0]));
  endsequence

  // Only the selected bit is written
  pin_mem_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pin_mem_cmd_s |=> mem_report_s) else $error("pin to mem mask wrong");

  // Written bit is the level sampled one instruction earlier
  pin_mem_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pin_mem_cmd_s |=> s_q.mem_data == ({4{$past(s_q.io_smp)}} & s_q.mem_mask)) else $error("pin bit wrong");

  // Status copy also turns the pin to output
  stat_pin_dir_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dbus.op == IOPB_STAT_PIN |=> !io_pin_oe_n_o) else $error("status pin not driven");

  // Whole port level goes to the addressed nibble
  port_mem_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dbus.op == IOPB_PORT_MEM |=> s_q.mem_wr && s_q.mem_mask == 4'hF && s_q.mem_data == $past(kline))
    else $error("port to mem wrong");

  // Port level goes to the accumulator
  port_acc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dbus.op == IOPB_PORT_ACC |=> s_q.acc == $past(kline)) else $error("port to acc wrong");

  // A driven port reads back its own latch
  port_view_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dbus.op == IOPB_PORT_ACC && s_q.dl[PORT_DIR_DL] |=> s_q.acc == $past(s_q.klat))
    else $error("driven port read wrong");

  // Segments A to G come from the decode term
  seg_term_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dbus.op == IOPB_SEG_OUT |=> seg_o[6:0] == $past(seg_ag)) else $error("segment term wrong");

  // Segment word goes to the digit chosen by Y
  seg_digit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dbus.op == IOPB_SEG_OUT |=> seg_digit_o == $past(s_q.y)) else $error("segment digit wrong");

  // Segment write strobe lasts one cycle
  seg_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    seg_wr_o |=> !seg_wr_o) else $error("segment strobe too long");

  // Point latch set
  point_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dbus.op == IOPB_DP_SET |=> s_q.dp) else $error("point not set");

  // Point latch clear
  point_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dbus.op == IOPB_DP_CLR |=> !s_q.dp) else $error("point not cleared");

  // Digit latch chosen by Y is set
  digit_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dbus.op == IOPB_DL_SET |=> s_q.dl[$past(s_q.y)]) else $error("digit not set");

  // Digit latch chosen by Y is cleared
  digit_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dbus.op == IOPB_DL_CLR |=> !s_q.dl[$past(s_q.y)]) else $error("digit not cleared");

  // Toggle flips the direct select and keeps X
  dam_toggle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dbus.op == IOPB_DAM_TGL |=> s_q.direct_access_bank != $past(s_q.direct_access_bank) && $stable(s_q.x))
    else $error("direct toggle wrong");

  // Memory write goes to the direct bank while selected, else to X
  bank_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pin_mem_cmd_s |=> s_q.mem_bank == ($past(s_q.direct_access_bank) ? DIRECT_BANK_CODE : $past(s_q.x)))
    else $error("memory bank wrong");

  // Bus acknowledge is a single-cycle pulse
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack too long");

  // Reset releases both pins and clears the R outputs
  reset_state_a: assert property (@(posedge clk_i)
    rst_i |=> io_pin_oe_n_o && kport_oe_n_o && r_o == 8'h00) else $error("reset state wrong");
endmodule : iopb_top
`default_nettype wire

/* File: verilog/iopb_pkg.sv */
// Package of constants and types for the I/O port and RAM bank instruction block
`default_nettype none
package iopb_pkg;
  // Opcodes (9-bit instruction words)
  localparam logic [8:0] OP_PIN_DRIVE_LOW = 9'h00B;
  localparam logic [8:0] OP_PIN_DRIVE_HIGH = 9'h00C;
  localparam logic [8:0] OP_PIN_TO_INPUT = 9'h01A;
  localparam logic [8:0] OP_STATUS_TO_PIN = 9'h00F;
  localparam logic [8:0] OP_PIN_TO_MEM_BASE = 9'h0AC;
  localparam logic [8:0] OP_ACC_TO_PORT = 9'h0B8;
  localparam logic [8:0] OP_PORT_TO_MEM = 9'h00A;
  localparam logic [8:0] OP_PORT_TO_ACC = 9'h008;
  localparam logic [8:0] OP_PORT_NONZERO = 9'h00E;
  localparam logic [8:0] OP_SEG_OUT = 9'h0B7;
  localparam logic [8:0] OP_POINT_SET = 9'h0B9;
  localparam logic [8:0] OP_POINT_CLEAR = 9'h0B6;
  localparam logic [8:0] OP_DIGIT_SET = 9'h00D;
  localparam logic [8:0] OP_DIGIT_CLEAR = 9'h036;
  localparam logic [8:0] OP_BANK_LOAD_BASE = 9'h090;
  localparam logic [8:0] OP_BANK_MSB_INV = 9'h0B2;
  localparam logic [8:0] OP_DIRECT_TOGGLE = 9'h0BC;
  // Digit latch indices with special meaning
  localparam int unsigned PORT_DIR_DL = 8;
  localparam int unsigned SEG_SEL_DL = 14;
  // Bank number seen when the direct-access bank is selected
  localparam logic [3:0] DIRECT_BANK_CODE = 4'hF;
  // Reset values
  localparam logic [3:0] X_RESET = 4'h0;
  localparam logic [15:0] DL_RESET = 16'h0000;
  localparam logic [3:0] PORT_LATCH_RESET = 4'h0;
  // Register bus map (word aligned byte addresses)
  localparam logic [7:0] ADR_INSTR = 8'h00;
  localparam logic [7:0] ADR_REGS = 8'h04;
  localparam logic [7:0] ADR_LATCH = 8'h08;
  localparam logic [7:0] ADR_MEMWR = 8'h0C;
  localparam logic [7:0] ADR_SEG = 8'h10;
  // Decoded instruction classes
  typedef enum logic [4:0] {
    IOPB_NONE, IOPB_PIN_LOW, IOPB_PIN_HIGH, IOPB_PIN_IN, IOPB_STAT_PIN, IOPB_PIN_MEM,
    IOPB_ACC_PORT, IOPB_PORT_MEM, IOPB_PORT_ACC, IOPB_PORT_NZ, IOPB_SEG_OUT,
    IOPB_DP_SET, IOPB_DP_CLR, IOPB_DL_SET, IOPB_DL_CLR, IOPB_X_LOAD, IOPB_X_MSB, IOPB_DAM_TGL
  } iopb_op_t;
endpackage : iopb_pkg
`default_nettype wire

/* File: verilog/iopb_exec_if.sv */
// Interface carrying a decoded instruction from the decoder to the executer
`default_nettype none
interface iopb_exec_if;
  import iopb_pkg::*;
  iopb_op_t op; // Decoded class
  logic [3:0] field; // Low four opcode bits (constant or bit number)
  modport dec (output op, output field);
  modport exe (input op, input field);
endinterface : iopb_exec_if
`default_nettype wire

/* File: verilog/iopb_decode.sv */
// Instruction decoder for the I/O port and RAM bank instructions
`default_nettype none
module iopb_decode
  import iopb_pkg::*;
(
  // Instruction word
  input wire logic [8:0] instr_i,
  // Decoded output
  iopb_exec_if.dec dec
);
  // Pure combinational decode of one opcode word
  always_comb begin
    dec.field = instr_i[3:0];
    dec.op = IOPB_NONE;
    if (instr_i[8:2] == OP_PIN_TO_MEM_BASE[8:2]) begin
      dec.op = IOPB_PIN_MEM;
    end else if (instr_i[8:4] == OP_BANK_LOAD_BASE[8:4]) begin
      dec.op = IOPB_X_LOAD;
    end else begin
      unique case (instr_i)
        OP_PIN_DRIVE_LOW: dec.op = IOPB_PIN_LOW;
        OP_PIN_DRIVE_HIGH: dec.op = IOPB_PIN_HIGH;
        OP_PIN_TO_INPUT: dec.op = IOPB_PIN_IN;
        OP_STATUS_TO_PIN: dec.op = IOPB_STAT_PIN;
        OP_ACC_TO_PORT: dec.op = IOPB_ACC_PORT;
        OP_PORT_TO_MEM: dec.op = IOPB_PORT_MEM;
        OP_PORT_TO_ACC: dec.op = IOPB_PORT_ACC;
        OP_PORT_NONZERO: dec.op = IOPB_PORT_NZ;
        OP_SEG_OUT: dec.op = IOPB_SEG_OUT;
        OP_POINT_SET: dec.op = IOPB_DP_SET;
        OP_POINT_CLEAR: dec.op = IOPB_DP_CLR;
        OP_DIGIT_SET: dec.op = IOPB_DL_SET;
        OP_DIGIT_CLEAR: dec.op = IOPB_DL_CLR;
        OP_BANK_MSB_INV: dec.op = IOPB_X_MSB;
        OP_DIRECT_TOGGLE: dec.op = IOPB_DAM_TGL;
        default: dec.op = IOPB_NONE;
      endcase
    end
  end
endmodule : iopb_decode
`default_nettype wire

/* File: verilog/iopb_segrom.sv */
// Segment decode array: 64 terms addressed by select latch, status and accumulator
`default_nettype none
module iopb_segrom (
  // Term address
  input wire logic [5:0] term_i,
  // Segments A to G
  output logic [6:0] seg_o
);
  // Seven-segment glyphs for hex digits, gfedcba
  function automatic logic [6:0] iopb_glyph(input logic [3:0] v);
    logic [6:0] g;
    g = 7'h00;
    unique case (v)
      4'h0: g = 7'h3F; 4'h1: g = 7'h06; 4'h2: g = 7'h5B; 4'h3: g = 7'h4F;
      4'h4: g = 7'h66; 4'h5: g = 7'h6D; 4'h6: g = 7'h7D; 4'h7: g = 7'h07;
      4'h8: g = 7'h7F; 4'h9: g = 7'h6F; 4'hA: g = 7'h77; 4'hB: g = 7'h7C;
      4'hC: g = 7'h39; 4'hD: g = 7'h5E; 4'hE: g = 7'h79; 4'hF: g = 7'h71;
    endcase
    return g;
  endfunction : iopb_glyph
  // Upper 48 terms: inverted glyphs, raw value, bank 3 blank; a mask option stands in
  always_comb begin
    unique case (term_i[5:4])
      2'h0: seg_o = iopb_glyph(term_i[3:0]);
      2'h1: seg_o = ~iopb_glyph(term_i[3:0]);
      2'h2: seg_o = {3'h0, term_i[3:0]};
      2'h3: seg_o = 7'h00;
    endcase
  end
endmodule : iopb_segrom
`default_nettype wire

/* File: tb/iopb_far_model.sv */
// Far-side model: a sensor on the single pin and a keypad on the port
`default_nettype none
module iopb_far_model (
  // Lines from the device
  input wire logic dev_pin_i,
  input wire logic dev_pin_oe_n_i,
  input wire logic [3:0] dev_k_i,
  input wire logic dev_k_oe_n_i,
  // Levels chosen by the bench
  input wire logic sense_i,
  input wire logic [3:0] keys_i,
  // Line levels seen by the device
  output logic pin_o,
  output logic [3:0] kport_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // A driven pin carries the data latch, a released one the sensor
  assign pin_o = dev_pin_oe_n_i ? sense_i : dev_pin_i;
  // A driven port carries the port latch, a released one the keys
  assign kport_o = dev_k_oe_n_i ? keys_i : dev_k_i;
endmodule : iopb_far_model
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the I/O port and RAM bank instruction block
`default_nettype none
module tb_top
  import iopb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, cyc, stb, we, ack, sense, pin_in, pin_out, pin_oe_n, k_oe_n, seg_wr;
  logic [7:0] adr, r_out, seg;
  logic [3:0] sel, keys, k_in, k_out, seg_dig, a, kv, c, y;
  logic [31:0] wdat, rdat, q;
  int num_errors = 0;
  int checks_done = 0;
  int seed = 4;
  int cycles = 0;
  int m_dl = 0; // Reference digit latches
  bit seg_seen;
  int banks[$] = '{1, 2, 3, 4, 7, 9, 10, 11, 12, 15};
  logic [8:0] ops[$] = '{OP_PIN_DRIVE_LOW, OP_PIN_DRIVE_HIGH, OP_PIN_TO_INPUT, OP_PIN_TO_MEM_BASE,
    OP_ACC_TO_PORT, OP_PORT_TO_MEM, OP_PORT_TO_ACC, OP_SEG_OUT, OP_POINT_SET, OP_POINT_CLEAR,
    OP_DIGIT_SET, OP_DIGIT_CLEAR, OP_BANK_MSB_INV, OP_DIRECT_TOGGLE, OP_BANK_LOAD_BASE | 9'h001};

  iopb_top dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .io_pin_i(pin_in), .io_pin_o(pin_out),
    .io_pin_oe_n_o(pin_oe_n), .kport_i(k_in), .kport_o(k_out), .kport_oe_n_o(k_oe_n), .r_o(r_out),
    .seg_o(seg), .seg_digit_o(seg_dig), .seg_wr_o(seg_wr));
  iopb_far_model far (.dev_pin_i(pin_out), .dev_pin_oe_n_i(pin_oe_n), .dev_k_i(k_out), .dev_k_oe_n_i(k_oe_n),
    .sense_i(sense), .keys_i(keys), .pin_o(pin_in), .kport_o(k_in));

  // Clock at 20 MHz
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard and segment write pulse catcher
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (seg_wr === 1'b1) seg_seen <= 1'b1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      complete_run();
    end
  end

  // Reference decode array: hex glyphs, inverted glyphs, raw value, blank
  function automatic logic [6:0] seg_ref(input logic [5:0] t);
    logic [6:0] gl[16];
    gl = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
      7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
    case (t[5:4])
      2'h0: return gl[t[3:0]];
      2'h1: return ~gl[t[3:0]];
      2'h2: return {3'h0, t[3:0]};
      default: return 7'h00;
    endcase
  endfunction : seg_ref

  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  // One comparison
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Classic single Wishbone cycle; waits for ack, the guard cuts a hang
  task automatic bus(input logic [7:0] ad, input logic w, input logic [3:0] s, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    sel <= s;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  // Register read into q
  task automatic rd(input logic [7:0] ad);
    bus(ad, 1'b0, 4'hF, 32'h0);
  endtask : rd

  // Execute one instruction and let its updates land
  task automatic ex(input logic [8:0] op);
    bus(ADR_INSTR, 1'b1, 4'h1, {23'h0, op});
    @(negedge clk);
  endtask : ex

  // Set status and accumulator
  task automatic sa(input logic st, input logic [3:0] ac);
    bus(ADR_REGS, 1'b1, 4'h2, {19'h0, st, ac, 8'h0});
  endtask : sa

  // Set Y
  task automatic sy(input logic [3:0] v);
    bus(ADR_REGS, 1'b1, 4'h1, {24'h0, v, 4'h0});
  endtask : sy

  // Status is seen by copying it to the pin
  task automatic sp(input logic e);
    ex(OP_STATUS_TO_PIN);
    chk({pin_out, pin_oe_n}, {e, 1'b0});
  endtask : sp

  // Pin to memory bit b, then read the reported memory write
  task automatic mw(input logic [1:0] b);
    ex(OP_PIN_TO_MEM_BASE | {7'h00, b});
    rd(ADR_MEMWR);
  endtask : mw

  initial begin
    {cyc, stb, we, sense, seg_seen} = '0;
    {adr, sel, wdat, keys} = '0;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({pin_oe_n, k_oe_n, r_out}, {2'b11, 8'h00});
    // Every non-test instruction leaves status set
    foreach (ops[i]) begin
      sa(1'b0, 4'h0);
      ex(ops[i]);
      sp(1'b1);
    end
    sa(1'b0, 4'h0);
    sp(1'b0);
    ex(OP_PIN_DRIVE_HIGH);
    chk({pin_out, pin_oe_n}, 2'b10);
    ex(OP_PIN_TO_INPUT);
    chk({pin_out, pin_oe_n}, 2'b11);
    ex(OP_PIN_DRIVE_LOW);
    chk({pin_out, pin_oe_n}, 2'b00);
    ex(OP_PIN_TO_INPUT);
    chk({pin_out, pin_oe_n}, 2'b01);
    $display("test pin latches done");
    // Bank select, direct bank and pin sampling
    sy(4'h5);
    foreach (banks[i]) begin
      c = 4'(banks[i]);
      sense <= 1'($random(seed));
      ex(OP_PIN_TO_INPUT);
      ex(OP_BANK_LOAD_BASE | {5'h00, c});
      mw(2'(i));
      chk(q[15:8], {c, 4'h5});
      chk({q[3:0], q[4 + i % 4], pin_oe_n}, {4'h1 << (i % 4), sense, 1'b1});
      ex(OP_DIRECT_TOGGLE);
      ex(OP_BANK_MSB_INV);
      mw(2'(i));
      chk(q[15:12], 4'hF);
      ex(OP_DIRECT_TOGGLE);
      mw(2'(i));
      chk(q[15:12], c ^ 4'h8);
      ex(OP_DIRECT_TOGGLE);
      ex(OP_BANK_LOAD_BASE | {5'h00, c});
      mw(2'(i));
      chk(q[15:12], c);
    end
    ex(OP_PIN_DRIVE_HIGH);
    ex(OP_PIN_DRIVE_HIGH);
    sense <= 1'b0;
    mw(2'h2);
    chk({q[6], pin_oe_n}, 2'b10);
    $display("test bank and pin read done");
    // Port latch, direction, reads and nonzero test
    for (int i = 0; i < 4; i++) begin
      a = (i == 1) ? 4'h0 : 4'($random(seed));
      kv = (i == 0) ? 4'h0 : 4'($random(seed));
      keys <= ~a;
      sa(1'b0, a);
      ex(OP_ACC_TO_PORT);
      chk({k_out, k_oe_n}, {a, 1'b1});
      sy(4'h8);
      ex(OP_DIGIT_SET);
      chk({k_out, k_oe_n}, {a, 1'b0});
      ex(OP_PORT_NONZERO);
      sp(a != 4'h0);
      ex(OP_PORT_TO_ACC);
      ex(OP_DIGIT_CLEAR);
      ex(OP_ACC_TO_PORT);
      chk(k_out, a);
      keys <= kv;
      ex(OP_PORT_TO_ACC);
      ex(OP_ACC_TO_PORT);
      chk({k_out, k_oe_n}, {kv, 1'b1});
      ex(OP_PORT_NONZERO);
      sp(kv != 4'h0);
      ex(OP_PORT_TO_MEM);
      rd(ADR_MEMWR);
      chk(q[11:0], {4'h8, kv, 4'hF});
    end
    $display("test port done");
    // Digit latches set then cleared through Y
    for (int i = 0; i < 32; i++) begin
      y = 4'(i);
      sy(y);
      ex(i < 16 ? OP_DIGIT_SET : OP_DIGIT_CLEAR);
      m_dl = i < 16 ? (m_dl | (1 << y)) : (m_dl & ~(1 << y));
      rd(ADR_LATCH);
      chk({q[31:16], r_out, k_oe_n}, {16'(m_dl), 8'(m_dl), ~m_dl[8]});
    end
    $display("test digit latches done");
    // Segment writes with the point latch on and off
    for (int i = 0; i < 4; i++) begin
      ex(i < 2 ? OP_POINT_SET : OP_POINT_CLEAR);
      sy(4'hE);
      ex(i[0] ? OP_DIGIT_SET : OP_DIGIT_CLEAR);
      y = 4'($random(seed));
      sy(y);
      c = 4'($random(seed));
      kv = 4'($random(seed));
      sa(kv[0], c);
      rd(ADR_INSTR);
      chk(q[4:0], {kv[0], c});
      seg_seen = 1'b0;
      ex(OP_SEG_OUT);
      repeat (2) @(negedge clk);
      chk({seg[7], seg_dig, seg_seen}, {i < 2, y, 1'b1});
      chk(seg[7], i < 2);
      chk(seg[6:0], seg_ref({i[0], kv[0], c}));
    end
    $display("test segments done");
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
